// >>> logic/frs_pkg.sv
// Constants for the flash row erase and write sequencer
package frs_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] OFS_CONTROL = 5'h00;
    localparam logic [4:0] OFS_UNLOCK = 5'h04;
    localparam logic [4:0] OFS_ADDR_LOW = 5'h08;
    localparam logic [4:0] OFS_ADDR_HIGH = 5'h0C;
    localparam logic [4:0] OFS_DATA_LOW = 5'h10;
    localparam logic [4:0] OFS_DATA_HIGH = 5'h14;
    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int BIT_READ = 0;
    localparam int BIT_WRITE_INIT = 1;
    localparam int BIT_WRITE_ENABLE_BIT = 2;
    localparam int BIT_WRERR = 3;
    localparam int BIT_ROW_ERASE = 4;
    localparam int BIT_LATCH_ONLY = 5;
    localparam int BIT_CFG_SPACE = 6;
    localparam int BIT_PGM_SEL = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // ------------------------------------------------------------
    // Unlock keys and word values
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [13:0] ERASED_WORD = 14'h3FFF;
    localparam int LATCH_COUNT = 32;
    localparam int LATCH_BITS = 5;
    localparam int FLASH_ADDR_BITS = 15;
    localparam int ROW_WORDS = 32;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int ERASE_TIME_US = 2000;
    localparam int ERASE_CYCLES = ERASE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int PROG_TIME_US = 2000;
    localparam int PROG_CYCLES = PROG_TIME_US * (CLK_HZ / 1_000_000);
    localparam int SETUP_CYCLES = 2;
    localparam int WORD_CYCLES = 1;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_ERASE, ST_PROGRAM, ST_DONE
    } frs_state_e;
    typedef enum logic [1:0] {
        KEY_NONE, KEY_GOT_FIRST, KEY_ARMED
    } frs_key_e;
endpackage

// >>> logic/frs_flash_sequencer.sv
// Flash row erase and latched block write sequencer with Avalon-MM slave
`timescale 1ns/1ns
// Overview of operation
// - Erase happens only per whole row
// - Key 55h then AAh unlocks initiate
// - Erase select clears on erase completion
// - Two setup cycles follow the initiate
// - Erase stalls core about 2 ms
// - Core resumes after the setup instructions
// - Programming never erases automatically
// - One program writes at most 32 words
// - Latch block aligned, never crosses boundary
// - Latches reset to 3FFF after programming
// - Latch-only flag set, erase clear: initiate just loads latch
// - Latch-only and erase clear: load last, program block
// - Program writes whole block, unloaded latches too
module frs_flash_sequencer
    import frs_pkg::*;
#(
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int PROG_CNT = PROG_CYCLES
) (
    input wire logic ref_clk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic [4:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall request
    output logic cpu_stall, // Halts instruction fetch
    output logic flash_we, // Word write strobe to array
    output logic flash_row_erase, // Row erase strobe to array
    output logic [14:0] flash_addr, // Array word address
    output logic [13:0] flash_wdata // Array write data
);
    localparam int CW = 24;
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    frs_state_e state_reg, state_next;
    frs_key_e key_reg, key_next;
    logic [7:0] control_reg, control_next;
    logic [7:0] addr_low_reg, addr_low_next;
    logic [6:0] addr_high_reg, addr_high_next;
    logic [7:0] data_low_reg, data_low_next;
    logic [5:0] data_high_reg, data_high_next;
    logic [CW-1:0] count_reg, count_next;
    logic [LATCH_BITS-1:0] idx_reg, idx_next;
    logic erase_op_reg, erase_op_next;
    logic [31:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    logic wait_reg, wait_next;
    logic stall_reg, stall_next;
    logic we_reg, we_next;
    logic erase_reg, erase_next;
    logic [14:0] faddr_reg, faddr_next;
    logic [13:0] fdata_reg, fdata_next;
    logic [13:0] latch_mem [LATCH_COUNT];
    logic latch_load;
    logic latch_clear;
    logic [LATCH_BITS-1:0] latch_sel;
    logic [13:0] latch_word;
    logic bus_wr;
    logic bus_rd;
    logic [14:0] cur_addr;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Writes land on the edge that sees waitrequest low; lane 0 gates them
    assign bus_wr = avs_write & ack_reg & avs_byteenable[0];
    // Read data is captured one edge early so it stands at the answer edge
    assign bus_rd = avs_read & ~ack_reg;
    assign cur_addr = {addr_high_reg, addr_low_reg};
    assign latch_sel = addr_low_reg[LATCH_BITS-1:0];
    assign latch_word = {data_high_reg, data_low_reg};

    // ------------------------------------------------------------
    // Write latches
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < LATCH_COUNT; gi++) begin : g_latch
            always_ff @(posedge ref_clk) begin
                if (!rstn || latch_clear) begin
                    latch_mem[gi] <= ERASED_WORD;
                end else if (latch_load &&
                        latch_sel == LATCH_BITS'(gi)) begin
                    latch_mem[gi] <= latch_word;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        key_next = key_reg;
        control_next = control_reg;
        addr_low_next = addr_low_reg;
        addr_high_next = addr_high_reg;
        data_low_next = data_low_reg;
        data_high_next = data_high_reg;
        count_next = count_reg;
        idx_next = idx_reg;
        erase_op_next = erase_op_reg;
        rdata_next = rdata_reg;
        ack_next = 1'b0;
        stall_next = stall_reg;
        we_next = 1'b0;
        erase_next = 1'b0;
        faddr_next = faddr_reg;
        fdata_next = fdata_reg;
        latch_load = 1'b0;
        latch_clear = 1'b0;
        // Every request is answered once, mapped or not, lane 0 or not
        if ((avs_read || avs_write) && !ack_reg) begin
            ack_next = 1'b1;
        end
        if (bus_rd) begin
            unique case (avs_address)
                OFS_CONTROL: rdata_next = {24'h000000, control_reg};
                OFS_ADDR_LOW: rdata_next = {24'h000000, addr_low_reg};
                OFS_ADDR_HIGH: rdata_next = {25'h0000000, addr_high_reg};
                OFS_DATA_LOW: rdata_next = {24'h000000, data_low_reg};
                OFS_DATA_HIGH: rdata_next = {26'h0000000, data_high_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
        if (bus_wr) begin
            // Any register write other than the second key breaks the chain
            if (!(avs_address == OFS_UNLOCK) &&
                    !(avs_address == OFS_CONTROL && key_reg == KEY_ARMED)) begin
                key_next = KEY_NONE;
            end
            unique case (avs_address)
                OFS_UNLOCK: begin
                    if (avs_writedata[7:0] == KEY_FIRST) begin
                        key_next = KEY_GOT_FIRST;
                    end else if (avs_writedata[7:0] == KEY_SECOND &&
                            key_reg == KEY_GOT_FIRST) begin
                        key_next = KEY_ARMED;
                    end else begin
                        key_next = KEY_NONE;
                    end
                end
                OFS_CONTROL: begin
                    key_next = KEY_NONE;
                    if (state_reg == ST_IDLE) begin
                        control_next = avs_writedata[7:0];
                        control_next[BIT_WRITE_INIT] = 1'b0;
                        control_next[BIT_READ] = 1'b0;
                        if (avs_writedata[BIT_WRITE_INIT] &&
                                key_reg == KEY_ARMED &&
                                avs_writedata[BIT_WRITE_ENABLE_BIT] &&
                                avs_writedata[BIT_PGM_SEL] &&
                                !avs_writedata[BIT_CFG_SPACE]) begin
                            control_next[BIT_WRITE_INIT] = 1'b1;
                            erase_op_next = avs_writedata[BIT_ROW_ERASE];
                            count_next = CW'(SETUP_CYCLES - 1);
                            stall_next = 1'b1;
                            state_next = ST_SETUP;
                        end
                    end
                end
                OFS_ADDR_LOW: addr_low_next = avs_writedata[7:0];
                OFS_ADDR_HIGH: addr_high_next = avs_writedata[6:0];
                OFS_DATA_LOW: data_low_next = avs_writedata[7:0];
                OFS_DATA_HIGH: data_high_next = avs_writedata[5:0];
                default: ;
            endcase
        end
        unique case (state_reg)
            ST_IDLE: ;
            ST_SETUP: begin
                if (count_reg == '0) begin
                    if (erase_op_reg) begin
                        // Whole row only: low address bits are dropped
                        faddr_next = cur_addr & ~15'(ROW_WORDS - 1);
                        erase_next = 1'b1;
                        count_next = CW'(ERASE_CNT - 1);
                        state_next = ST_ERASE;
                    end else if (control_reg[BIT_LATCH_ONLY]) begin
                        latch_load = 1'b1;
                        state_next = ST_DONE;
                    end else begin
                        latch_load = 1'b1;
                        idx_next = '0;
                        count_next = CW'(PROG_CNT - 1);
                        state_next = ST_PROGRAM;
                    end
                end else begin
                    count_next = count_reg - CW'(1);
                end
            end
            ST_ERASE: begin
                if (count_reg == '0) begin
                    control_next[BIT_ROW_ERASE] = 1'b0;
                    state_next = ST_DONE;
                end else begin
                    count_next = count_reg - CW'(1);
                end
            end
            ST_PROGRAM: begin
                // Every latch goes out, loaded or not; no erase here
                if (count_reg == CW'(PROG_CNT - 1) - CW'(idx_reg)) begin
                    faddr_next = {cur_addr[14:LATCH_BITS], idx_reg};
                    fdata_next = latch_mem[idx_reg];
                    we_next = 1'b1;
                    // Index parks on the last latch: one pulse per latch
                    if (idx_reg != LATCH_BITS'(LATCH_COUNT - 1)) begin
                        idx_next = idx_reg + LATCH_BITS'(1);
                    end
                end
                if (count_reg == '0) begin
                    latch_clear = 1'b1;
                    state_next = ST_DONE;
                end else begin
                    count_next = count_reg - CW'(1);
                end
            end
            // Release the core and drop the initiate bit together
            ST_DONE: begin
                control_next[BIT_WRITE_INIT] = 1'b0;
                stall_next = 1'b0;
                faddr_next = '0;
                state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
        // Own flop so the pin leaves a register with no gate behind it
        wait_next = ~ack_next;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg <= ST_IDLE;
            key_reg <= KEY_NONE;
            control_reg <= CONTROL_RESET;
            addr_low_reg <= 8'h00;
            addr_high_reg <= 7'h00;
            data_low_reg <= 8'h00;
            data_high_reg <= 6'h00;
            count_reg <= '0;
            idx_reg <= '0;
            erase_op_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            ack_reg <= 1'b0;
            wait_reg <= 1'b1;
            stall_reg <= 1'b0;
            we_reg <= 1'b0;
            erase_reg <= 1'b0;
            faddr_reg <= 15'h0000;
            fdata_reg <= 14'h0000;
        end else begin
            state_reg <= state_next;
            key_reg <= key_next;
            control_reg <= control_next;
            addr_low_reg <= addr_low_next;
            addr_high_reg <= addr_high_next;
            data_low_reg <= data_low_next;
            data_high_reg <= data_high_next;
            count_reg <= count_next;
            idx_reg <= idx_next;
            erase_op_reg <= erase_op_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
            wait_reg <= wait_next;
            stall_reg <= stall_next;
            we_reg <= we_next;
            erase_reg <= erase_next;
            faddr_reg <= faddr_next;
            fdata_reg <= fdata_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_readdata = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign cpu_stall = stall_reg;
    assign flash_we = we_reg;
    assign flash_row_erase = erase_reg;
    assign flash_addr = faddr_reg;
    assign flash_wdata = fdata_reg;
endmodule // frs_flash_sequencer

// >>> verif/frs_flash_sequencer_assertions.sv
// Port-level checks for the flash sequencer
`timescale 1ns/1ns
module frs_flash_sequencer_checker
    import frs_pkg::*;
#(
    parameter int ERASE_CNT = ERASE_CYCLES,
    parameter int PROG_CNT = PROG_CYCLES
) (
    input wire logic ref_clk, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic [4:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall request
    input wire logic cpu_stall, // Core halt
    input wire logic flash_we, // Word write strobe
    input wire logic flash_row_erase, // Row erase strobe
    input wire logic [14:0] flash_addr, // Array address
    input wire logic [13:0] flash_wdata // Array data
);
    // ----
    // Stall length, erase seen and word count tracking
    // ----
    logic [31:0] stall_cnt_reg, stall_cnt_next;
    logic [7:0] we_cnt_reg, we_cnt_next;
    logic erased_reg, erased_next;
    always_comb begin
        stall_cnt_next = cpu_stall ? stall_cnt_reg + 32'h1 : 32'h0;
        we_cnt_next = cpu_stall ? we_cnt_reg + {7'h00, flash_we} : 8'h00;
        erased_next = cpu_stall & (erased_reg | flash_row_erase);
    end
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            stall_cnt_reg <= 32'h0;
            we_cnt_reg <= 8'h00;
            erased_reg <= 1'h0;
        end else begin
            stall_cnt_reg <= stall_cnt_next;
            we_cnt_reg <= we_cnt_next;
            erased_reg <= erased_next;
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_quiet;
        !flash_we && !flash_row_erase && cpu_stall;
    endsequence
    AST_ACK_NEXT: assert property (s_taken |=> !avs_waitrequest)
        else $error("request not answered in next cycle");
    AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    AST_SETUP: assert property ($rose(cpu_stall) |-> s_quiet [*2])
        else $error("array touched during setup cycles");
    AST_ROW_ALIGN: assert property (flash_row_erase |-> flash_addr[4:0] == 5'h00)
        else $error("erase address not row aligned");
    AST_ERASE_HOLD: assert property (flash_row_erase |=> cpu_stall [*8])
        else $error("core released during erase");
    AST_ERASE_LEN: assert property ($fell(cpu_stall) && erased_reg |-> stall_cnt_reg >= ERASE_CNT)
        else $error("erase stall too short");
    AST_WE_START: assert property ($rose(flash_we) |-> flash_addr[4:0] == 5'h00)
        else $error("block write not aligned");
    AST_WE_STEP: assert property (flash_we && $past(flash_we) |-> flash_addr == $past(flash_addr) + 15'h1 && flash_addr[4:0] != 5'h00)
        else $error("block write address step wrong");
    AST_WE_MAX: assert property (we_cnt_reg <= 8'h20)
        else $error("more words than latches");
    AST_WE_ONLY: assert property (flash_we |-> cpu_stall && !flash_row_erase)
        else $error("write mixed with erase or without stall");
    AST_STALL_MAX: assert property (stall_cnt_reg <= ERASE_CNT + PROG_CNT + 64)
        else $error("operation never finished");
endmodule // frs_flash_sequencer_checker

bind frs_flash_sequencer frs_flash_sequencer_checker #(
    .ERASE_CNT(ERASE_CNT), .PROG_CNT(PROG_CNT)) u_chk (.*);

// >>> verif/frs_flash_sequencer_tb.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ns
module frs_flash_sequencer_tb;
    import frs_pkg::*;
    logic ref_clk = 1'h0;
    logic rstn = 1'h0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, cpu_stall, flash_we, flash_row_erase;
    logic [14:0] flash_addr, er_addr, we_addr;
    logic [13:0] flash_wdata;
    logic [13:0] we_data [32];
    int err_count = 0;
    int samples_checked = 0;
    int we_cnt = 0;
    int er_cnt = 0;
    int stall_cyc = 0;
    frs_flash_sequencer #(.ERASE_CNT(40), .PROG_CNT(40)) u_dut (
        .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cpu_stall(cpu_stall), .flash_we(flash_we),
        .flash_row_erase(flash_row_erase), .flash_addr(flash_addr),
        .flash_wdata(flash_wdata));
    always #20 ref_clk = ~ref_clk;
    // ----
    // Array side monitor
    // ----
    always @(posedge ref_clk) begin
        if (flash_we) begin
            we_data[flash_addr[4:0]] = flash_wdata;
            we_addr = flash_addr;
            we_cnt++;
        end
        if (flash_row_erase) begin
            er_addr = flash_addr;
            er_cnt++;
        end
        if (cpu_stall) stall_cyc++;
    end
    // ----
    // Tasks
    // ----
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, d};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'h0) @(posedge ref_clk);
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    // Keys, control write, then poll until the initiate bit drops
    task automatic op(input logic [7:0] c);
        bus(1'h1, OFS_UNLOCK, KEY_FIRST);
        bus(1'h1, OFS_UNLOCK, KEY_SECOND);
        bus(1'h1, OFS_CONTROL, c);
        repeat (200) begin
            bus(1'h0, OFS_CONTROL, 8'h00);
            if (rd[BIT_WRITE_INIT] === 1'h0) break;
        end
    endtask
    task automatic load(input logic [7:0] lo, input logic [7:0] d);
        bus(1'h1, OFS_ADDR_LOW, lo);
        bus(1'h1, OFS_DATA_LOW, d);
    endtask
    task automatic chk_block(input int lo, input int hi, input logic [7:0] b);
        logic [13:0] exp;
        for (int i = 0; i < LATCH_COUNT; i++) begin
            exp = (i >= lo && i <= hi) ? {6'h15, b + 8'(i)} : ERASED_WORD;
            check("latch word", {18'h0, we_data[i]}, {18'h0, exp});
        end
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d, comparisons %0d", err_count,
                 samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        tally_and_finish;
    end
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (5) @(posedge ref_clk);
        check("wait in reset", {31'h0, avs_waitrequest}, 32'h1);
        rstn <= 1'h1;
        bus(1'h0, OFS_CONTROL, 8'h00);
        check("control reset", rd, {24'h0, CONTROL_RESET});
        bus(1'h0, 5'h18, 8'h00);
        check("unmapped read", rd, 32'h0);
        bus(1'h1, OFS_CONTROL, 8'h86);
        bus(1'h0, OFS_CONTROL, 8'h00);
        check("no keys", rd, 32'h84);
        op(8'h82);
        check("no enable", rd, 32'h80);
        bus(1'h1, OFS_UNLOCK, KEY_FIRST);
        bus(1'h1, OFS_ADDR_LOW, 8'h00);
        bus(1'h1, OFS_UNLOCK, KEY_SECOND);
        bus(1'h1, OFS_CONTROL, 8'h86);
        bus(1'h0, OFS_CONTROL, 8'h00);
        check("broken chain", rd, 32'h84);
        check("idle array", 32'(we_cnt + er_cnt), 32'h0);
        bus(1'h1, OFS_ADDR_LOW, 8'h25);
        bus(1'h1, OFS_ADDR_HIGH, 8'h01);
        stall_cyc = 0;
        op(8'h96);
        check("erase done", rd, 32'h84);
        check("erase addr", {17'h0, er_addr}, 32'h120);
        check("erase count", 32'(er_cnt), 32'h1);
        check("erase stall", {31'h0, stall_cyc >= 40}, 32'h1);
        check("stall end", {31'h0, cpu_stall}, 32'h0);
        check("no write", 32'(we_cnt), 32'h0);
        bus(1'h1, OFS_ADDR_HIGH, 8'h02);
        bus(1'h1, OFS_DATA_HIGH, 8'h15);
        for (int i = 0; i < 3; i++) begin
            load(8'h40 + 8'(i), 8'hA0 + 8'(i));
            op(8'hA6);
            check("latch only", rd, 32'hA4);
        end
        check("no program", 32'(we_cnt), 32'h0);
        load(8'h43, 8'hA3);
        op(8'h86);
        check("program done", rd, 32'h84);
        check("word count", 32'(we_cnt), 32'h20);
        check("last addr", {17'h0, we_addr}, 32'h25F);
        chk_block(0, 3, 8'hA0);
        we_cnt = 0;
        load(8'h45, 8'h5A);
        op(8'h86);
        check("second count", 32'(we_cnt), 32'h20);
        chk_block(5, 5, 8'h55);
        tally_and_finish;
    end
endmodule // frs_flash_sequencer_tb
